// ---- hdl/flash_cmd_pkg.sv ----
// Purpose: shared constants for the serial flash command ends
// Assumes: 100 MHz pclk, spi mode 0 on the link
// Notes:   times in ns, cycle counts derived from them
package flash_cmd_pkg;
  localparam int CLK_MHZ = 100;

  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP   = 8'h02;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_SE   = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE1  = 8'hC7;
  localparam logic [7:0] OP_CE2  = 8'h60;
  localparam logic [7:0] OP_HALT = 8'h75;
  localparam logic [7:0] OP_RES  = 8'h7A;
  localparam logic [7:0] OP_PD   = 8'hB9;
  localparam logic [7:0] OP_FAST = 8'hA3;
  localparam logic [7:0] OP_REL  = 8'hAB;
  localparam logic [7:0] OP_MID  = 8'h90;

  // identity bytes: values are arbitrary
  localparam logic [7:0] MANUF_ID  = 8'h5A;
  localparam logic [7:0] DEVICE_ID = 8'h15;

  localparam int FULL_ERASE_TIME_NS   = 2000000;
  localparam int SECTOR_ERASE_TIME_NS = 400000;
  localparam int PROGRAM_TIME_NS      = 50000;
  localparam int SUSPEND_TIME_NS      = 20000;
  localparam int SLEEP_ENTRY_TIME_NS  = 3000;
  localparam int WAKE_TIME_NS         = 3000;
  localparam int WAKE_WITH_ID_TIME_NS = 5000;

  // longest times round down, least times round up
  localparam int FULL_ERASE_CYC   = FULL_ERASE_TIME_NS * CLK_MHZ / 1000;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_NS * CLK_MHZ / 1000;
  localparam int PROGRAM_CYC      = PROGRAM_TIME_NS * CLK_MHZ / 1000;
  localparam int SUSPEND_CYC      = SUSPEND_TIME_NS * CLK_MHZ / 1000;
  localparam int SLEEP_ENTRY_CYC  = SLEEP_ENTRY_TIME_NS * CLK_MHZ / 1000;
  localparam int WAKE_CYC         = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_WITH_ID_CYC = (WAKE_WITH_ID_TIME_NS * CLK_MHZ + 999) / 1000;

  localparam int OPW = 24;
  localparam int TW  = 12;

  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_CHIP = 2'h1;
  localparam logic [1:0] KIND_SECT = 2'h2;
  localparam logic [1:0] KIND_PROG = 2'h3;

  localparam int ST_BUSY   = 0;
  localparam int ST_WEN    = 1;
  localparam int ST_BP_LO  = 2;
  localparam int ST_BOTTOM = 5;
  localparam int ST_SMALL  = 6;
  localparam int ST_PAUSED = 7;

  localparam logic [2:0] ADDR_LAST_BYTE = 3'h3;
  localparam logic [2:0] DATA_BYTE      = 3'h4;
  localparam logic [2:0] SAT_BYTES      = 3'h7;

  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_GAP  = 8'h0C;
  localparam int CMD_TX_LO = 8;
  localparam int CMD_RX_LO = 12;
  localparam int CMD_GO    = 31;
  localparam logic [15:0] GAP_RESET = 16'(WAKE_WITH_ID_CYC);
  localparam logic [3:0] SCLK_HALF_CYC = 4'h8;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SHIFT = 2'b01,
    H_TAIL  = 2'b10,
    H_GAP   = 2'b11
  } host_state_t;
endpackage

// ---- hdl/spi_link_if.sv ----
// Purpose: serial link between flash command host and device
// Assumes: single data in, single data out, select active low
// Notes:   data out line idles high when the device does not drive it
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  assign miso_line = miso_oe ? miso : 1'b1;

  modport device (input cs_n, input sclk, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, input miso_line);
endinterface
`default_nettype wire

// ---- hdl/flash_cmd_dev.sv ----
// Purpose: command handling end of a serial nor flash
// Assumes: link pins oversampled by pclk, sclk at most pclk/6
// Notes:   one op timer; status byte served during any busy cycle
// Function
// - C7h or 60h erase whole array to ones
// - whole erase needs write enable latch set
// - select must rise right after eighth bit
// - self-timed whole erase, busy high, status served
// - write enable latch clears after whole erase
// - any protected page skips whole erase
// - 75h pauses sector/block erase or program
// - no status write or erase during erase pause
// - suspend ignored during whole array erase
// - no status write or program during program pause
// - suspend within latency, busy low, flag set
// - reset leaves no pause and flag clear
// - 7Ah sets busy, clears flag, finishes op
// - resume ignored unless pause active
// - B9h enters sleep within entry time
// - asleep only ABh recognised; start awake
// - A3h opcode plus three dummy bytes
// - ABh, 06h or B9h leave high speed
// - plain release waits wake time before commands
// - ABh plus three dummies repeats id byte
// - release with id waits longer wake time
// - ABh ignored while busy
// - 90h alternates maker and device id bytes
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_dev #(
  parameter int FULL_ERASE_CYC   = flash_cmd_pkg::FULL_ERASE_CYC,
  parameter int SECTOR_ERASE_CYC = flash_cmd_pkg::SECTOR_ERASE_CYC,
  parameter int PROGRAM_CYC      = flash_cmd_pkg::PROGRAM_CYC
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  spi_link_if.device  link,
  input  wire logic   protect_invert,
  input  wire logic   protect_small_unit,
  input  wire logic   protect_from_bottom,
  input  wire logic   prot_level_2,
  input  wire logic   prot_level_1,
  input  wire logic   prot_level_0,
  output logic        busy,
  output logic        write_enable_latch,
  output logic        paused_op_flag,
  output logic        asleep,
  output logic        high_speed_standby,
  output logic        array_blank
);
  typedef struct packed {
    logic [2:0]                      cs_sy;
    logic [2:0]                      ck_sy;
    logic [1:0]                      di_sy;
    logic [7:0]                      sh;
    logic [7:0]                      op;
    logic [2:0]                      bitc;
    logic [2:0]                      bytec;
    logic                            par;
    logic                            alsb;
    logic                            ign;
    logic                            miso;
    logic                            miso_oe;
    logic                            busy;
    logic                            wen;
    logic                            paused;
    logic                            suspending;
    logic                            asleep;
    logic                            hs;
    logic                            blank;
    logic [1:0]                      kind;
    logic [flash_cmd_pkg::OPW-1:0]   op_cnt;
    logic [flash_cmd_pkg::TW-1:0]    sus_cnt;
    logic [flash_cmd_pkg::TW-1:0]    pd_cnt;
    logic [flash_cmd_pkg::TW-1:0]    wake_cnt;
  } dev_state_t;

  localparam dev_state_t DEV_RST = '{cs_sy: 3'h7, default: '0};

  dev_state_t s;
  dev_state_t n;

  logic       cs_fall;
  logic       cs_rise;
  logic       ck_rise;
  logic       ck_fall;
  logic [7:0] new_byte;
  logic       exact1;
  logic       hdr_only;
  logic       reading;
  logic [7:0] status_byte;
  logic [7:0] out_byte;
  logic [2:0] bp;

  function automatic logic any_protected(input logic inv, input logic sec, input logic [2:0] lv);
    // complement mode only leaves the array open when the base range is everything
    any_protected = inv ? !(lv == 3'h7 && !sec) : (lv != 3'h0);
  endfunction

  assign bp       = {prot_level_2, prot_level_1, prot_level_0};
  assign cs_fall  = s.cs_sy[2] & ~s.cs_sy[1];
  assign cs_rise  = ~s.cs_sy[2] & s.cs_sy[1];
  assign ck_rise  = ~s.ck_sy[2] & s.ck_sy[1] & ~s.cs_sy[1] & ~s.ign;
  assign ck_fall  = s.ck_sy[2] & ~s.ck_sy[1] & ~s.cs_sy[1] & ~s.ign;
  assign new_byte = {s.sh[6:0], s.di_sy[1]};
  assign exact1   = (s.bitc == 3'h0) && (s.bytec == 3'h1);
  assign hdr_only = (s.bitc == 3'h0) && (s.bytec == flash_cmd_pkg::DATA_BYTE);

  assign status_byte = {s.paused, protect_small_unit, protect_from_bottom, bp, s.wen, s.busy};

  always_comb begin
    reading  = 1'b0;
    out_byte = status_byte;
    if (!s.asleep) begin
      if (s.op == flash_cmd_pkg::OP_RDSR && s.bytec != 3'h0) begin
        reading = 1'b1;
      end else if (s.op == flash_cmd_pkg::OP_MID && !s.busy &&
                   s.bytec >= flash_cmd_pkg::DATA_BYTE) begin
        reading  = 1'b1;
        out_byte = (s.par ^ s.alsb) ? flash_cmd_pkg::DEVICE_ID : flash_cmd_pkg::MANUF_ID;
      end
    end
    if (s.op == flash_cmd_pkg::OP_REL && !s.busy && s.bytec >= flash_cmd_pkg::DATA_BYTE) begin
      reading  = 1'b1;
      out_byte = flash_cmd_pkg::DEVICE_ID;
    end
  end

  always_comb begin
    n       = s;
    n.cs_sy = {s.cs_sy[1:0], link.cs_n};
    n.ck_sy = {s.ck_sy[1:0], link.sclk};
    n.di_sy = {s.di_sy[0], link.mosi};

    // op timer; a suspend only lands if the op is still running
    if (s.busy) begin
      if (s.op_cnt <= flash_cmd_pkg::OPW'(1)) begin
        n.busy       = 1'b0;
        n.wen        = 1'b0;
        n.suspending = 1'b0;
        n.kind       = flash_cmd_pkg::KIND_NONE;
        if (s.kind == flash_cmd_pkg::KIND_CHIP) begin
          n.blank = 1'b1;
        end
      end else begin
        n.op_cnt = s.op_cnt - flash_cmd_pkg::OPW'(1);
        if (s.suspending) begin
          if (s.sus_cnt <= flash_cmd_pkg::TW'(1)) begin
            n.busy       = 1'b0;
            n.paused     = 1'b1;
            n.suspending = 1'b0;
          end else begin
            n.sus_cnt = s.sus_cnt - flash_cmd_pkg::TW'(1);
          end
        end
      end
    end
    if (s.pd_cnt != '0) begin
      n.pd_cnt = s.pd_cnt - flash_cmd_pkg::TW'(1);
      if (s.pd_cnt == flash_cmd_pkg::TW'(1)) begin
        n.asleep = 1'b1;
      end
    end
    if (s.wake_cnt != '0) begin
      n.wake_cnt = s.wake_cnt - flash_cmd_pkg::TW'(1);
    end

    if (cs_fall) begin
      n.bitc  = 3'h0;
      n.bytec = 3'h0;
      n.par   = 1'b0;
      n.alsb  = 1'b0;
      n.op    = 8'h00;
      n.ign   = (s.wake_cnt != '0) || (s.pd_cnt != '0);
    end

    if (ck_rise) begin
      n.sh   = new_byte;
      n.bitc = s.bitc + 3'h1;
      if (s.bitc == 3'h7) begin
        n.par = ~s.par;
        if (s.bytec != flash_cmd_pkg::SAT_BYTES) begin
          n.bytec = s.bytec + 3'h1;
        end
        if (s.bytec == 3'h0) begin
          n.op = new_byte;
        end
        if (s.bytec == flash_cmd_pkg::ADDR_LAST_BYTE) begin
          n.alsb = new_byte[0];
        end
      end
    end

    if (ck_fall && reading) begin
      n.miso    = out_byte[3'h7 - s.bitc];
      n.miso_oe = 1'b1;
    end

    if (cs_rise) begin
      n.miso_oe = 1'b0;
    end
    if (cs_rise && !s.ign) begin
      if (s.asleep) begin
        // only the release opcode is heard while asleep
        if (s.op == flash_cmd_pkg::OP_REL && exact1) begin
          n.asleep   = 1'b0;
          n.hs       = 1'b0;
          n.wake_cnt = flash_cmd_pkg::TW'(flash_cmd_pkg::WAKE_CYC);
        end else if (s.op == flash_cmd_pkg::OP_REL && s.bitc == 3'h0 &&
                     s.bytec >= flash_cmd_pkg::DATA_BYTE) begin
          n.asleep   = 1'b0;
          n.hs       = 1'b0;
          n.wake_cnt = flash_cmd_pkg::TW'(flash_cmd_pkg::WAKE_WITH_ID_CYC);
        end
      end else begin
        case (s.op)
          flash_cmd_pkg::OP_WREN: begin
            if (exact1) begin
              n.wen = 1'b1;
              n.hs  = 1'b0;
            end
          end
          flash_cmd_pkg::OP_CE1, flash_cmd_pkg::OP_CE2: begin
            if (exact1 && s.wen && !s.busy && !s.paused &&
                !any_protected(protect_invert, protect_small_unit, bp)) begin
              n.busy   = 1'b1;
              n.kind   = flash_cmd_pkg::KIND_CHIP;
              n.op_cnt = flash_cmd_pkg::OPW'(FULL_ERASE_CYC);
            end
          end
          flash_cmd_pkg::OP_SE, flash_cmd_pkg::OP_BE32, flash_cmd_pkg::OP_BE64: begin
            if (hdr_only && s.wen && !s.busy && !s.paused) begin
              n.busy   = 1'b1;
              n.kind   = flash_cmd_pkg::KIND_SECT;
              n.op_cnt = flash_cmd_pkg::OPW'(SECTOR_ERASE_CYC);
            end
          end
          flash_cmd_pkg::OP_PP: begin
            if (s.bitc == 3'h0 && s.bytec > flash_cmd_pkg::DATA_BYTE &&
                s.wen && !s.busy && !s.paused) begin
              n.busy   = 1'b1;
              n.blank  = 1'b0;
              n.kind   = flash_cmd_pkg::KIND_PROG;
              n.op_cnt = flash_cmd_pkg::OPW'(PROGRAM_CYC);
            end
          end
          flash_cmd_pkg::OP_HALT: begin
            // an op ending this cycle must not leave a stale suspend behind
            if (exact1 && s.busy && !s.suspending && s.op_cnt > flash_cmd_pkg::OPW'(1) &&
                s.kind != flash_cmd_pkg::KIND_CHIP) begin
              n.suspending = 1'b1;
              n.sus_cnt    = flash_cmd_pkg::TW'(flash_cmd_pkg::SUSPEND_CYC);
            end
          end
          flash_cmd_pkg::OP_RES: begin
            if (exact1 && s.paused) begin
              n.paused = 1'b0;
              n.busy   = 1'b1;
            end
          end
          flash_cmd_pkg::OP_PD: begin
            if (exact1 && !s.busy) begin
              n.pd_cnt = flash_cmd_pkg::TW'(flash_cmd_pkg::SLEEP_ENTRY_CYC);
              n.hs     = 1'b0;
            end
          end
          flash_cmd_pkg::OP_FAST: begin
            if (hdr_only && !s.busy) begin
              n.hs = 1'b1;
            end
          end
          flash_cmd_pkg::OP_REL: begin
            if (!s.busy && s.bitc == 3'h0 && s.bytec != 3'h0) begin
              n.hs = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // power loss is modelled by reset: no pause survives it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= DEV_RST;
    end else begin
      s <= n;
    end
  end

  assign link.miso          = s.miso;
  assign link.miso_oe       = s.miso_oe;
  assign busy               = s.busy;
  assign write_enable_latch = s.wen;
  assign paused_op_flag     = s.paused;
  assign asleep             = s.asleep;
  assign high_speed_standby = s.hs;
  assign array_blank        = s.blank;
endmodule
`default_nettype wire

// ---- hdl/flash_cmd_host.sv ----
// Purpose: apb controlled host that issues flash command frames
// Assumes: software sequences legal commands and checks status
// Notes:   sclk made here by divider; select held high for gap afterwards
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  spi_link_if.host         link
);
  typedef struct packed {
    logic [1:0]                 mi_sy;
    flash_cmd_pkg::host_state_t st;
    logic [3:0]                 div;
    logic [7:0]                 bitn;
    logic [7:0]                 total;
    logic [63:0]                tx;
    logic [7:0]                 rx;
    logic                       cs_n;
    logic                       sclk;
    logic                       mosi;
    logic [7:0]                 opc;
    logic [2:0]                 ntx;
    logic [3:0]                 nrx;
    logic [23:0]                addr;
    logic [15:0]                gap;
    logic [15:0]                gap_cnt;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
  } host_reg_t;

  localparam host_reg_t HOST_RST = '{
    mi_sy: 2'h3, st: flash_cmd_pkg::H_IDLE, cs_n: 1'b1,
    gap: flash_cmd_pkg::GAP_RESET, default: '0};

  host_reg_t s;
  host_reg_t n;
  logic      tick;
  logic      mapped;
  logic [31:0] rd;

  assign tick   = (s.div == flash_cmd_pkg::SCLK_HALF_CYC - 4'h1);
  assign mapped = (paddr == flash_cmd_pkg::REG_CMD) || (paddr == flash_cmd_pkg::REG_ADDR) ||
                  (paddr == flash_cmd_pkg::REG_STAT) || (paddr == flash_cmd_pkg::REG_GAP);

  always_comb begin
    case (paddr)
      flash_cmd_pkg::REG_CMD:  rd = {16'h0, s.nrx, 1'b0, s.ntx, s.opc};
      flash_cmd_pkg::REG_ADDR: rd = {8'h0, s.addr};
      flash_cmd_pkg::REG_STAT: rd = {16'h0, s.rx, 6'h0,
                                     s.st == flash_cmd_pkg::H_GAP,
                                     s.st == flash_cmd_pkg::H_SHIFT || s.st == flash_cmd_pkg::H_TAIL};
      flash_cmd_pkg::REG_GAP:  rd = {16'h0, s.gap};
      default:                 rd = 32'h0;
    endcase
  end

  always_comb begin
    n       = s;
    n.mi_sy = {s.mi_sy[0], link.miso_line};
    n.div   = (tick || s.st == flash_cmd_pkg::H_IDLE) ? 4'h0 : s.div + 4'h1;

    case (s.st)
      flash_cmd_pkg::H_SHIFT: begin
        if (tick) begin
          if (!s.sclk) begin
            n.sclk = 1'b1;
            n.rx   = {s.rx[6:0], s.mi_sy[1]};
            n.bitn = s.bitn + 8'h1;
          end else begin
            n.sclk = 1'b0;
            if (s.bitn == s.total) begin
              n.st = flash_cmd_pkg::H_TAIL;
            end else begin
              n.tx   = {s.tx[62:0], 1'b0};
              n.mosi = s.tx[62];
            end
          end
        end
      end
      flash_cmd_pkg::H_TAIL: begin
        if (tick) begin
          n.cs_n    = 1'b1;
          n.st      = flash_cmd_pkg::H_GAP;
          n.gap_cnt = s.gap;
        end
      end
      flash_cmd_pkg::H_GAP: begin
        // select stays high through the gap so a wake time is honoured
        if (s.gap_cnt == 16'h0) begin
          n.st = flash_cmd_pkg::H_IDLE;
        end else begin
          n.gap_cnt = s.gap_cnt - 16'h1;
        end
      end
      default: begin
      end
    endcase

    if (psel && penable && !s.pready) begin
      n.pready  = 1'b1;
      n.prdata  = rd;
      n.pslverr = !mapped;
    end else if (psel && penable && s.pready) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite) begin
        case (paddr)
          flash_cmd_pkg::REG_CMD: begin
            n.opc = pwdata[7:0];
            n.ntx = pwdata[flash_cmd_pkg::CMD_TX_LO +: 3];
            n.nrx = pwdata[flash_cmd_pkg::CMD_RX_LO +: 4];
            // a start during a frame or gap is dropped, not queued
            if (pwdata[flash_cmd_pkg::CMD_GO] && s.st == flash_cmd_pkg::H_IDLE) begin
              n.st    = flash_cmd_pkg::H_SHIFT;
              n.cs_n  = 1'b0;
              n.sclk  = 1'b0;
              n.bitn  = 8'h0;
              n.tx    = {pwdata[7:0], s.addr, 32'h0};
              n.mosi  = pwdata[7];
              n.total = {5'(5'(pwdata[flash_cmd_pkg::CMD_TX_LO +: 3]) +
                            5'(pwdata[flash_cmd_pkg::CMD_RX_LO +: 4]) + 5'h1), 3'h0};
            end
          end
          flash_cmd_pkg::REG_ADDR: n.addr = pwdata[23:0];
          flash_cmd_pkg::REG_GAP:  n.gap  = pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= HOST_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign link.cs_n = s.cs_n;
  assign link.sclk = s.sclk;
  assign link.mosi = s.mosi;
endmodule
`default_nettype wire

// ---- test/flash_cmd_link_chk.sv ----
// Purpose: link checks between flash host and flash device
// Assumes: pclk samples every link signal
// Notes:   sclk half period of 8 pclk fixed by the host
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_link_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  a_sclk_high_half: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("sclk high phase wrong");
  a_sclk_low_half: assert property ($fell(sclk) |-> !sclk[*8])
    else $error("sclk low phase short");
  a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved with sclk high");
  a_miso_hold: assert property (miso_oe && sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved with sclk high");
  a_quiet_opcode: assert property ($fell(cs_n) |-> (!miso_oe && !sclk)[*7])
    else $error("drive or clock at frame start");
  a_release_out: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
    else $error("miso still driven after select");
  a_gap_hold: assert property ($rose(cs_n) |-> cs_n[*8])
    else $error("select gap too short");
endmodule
`default_nettype wire

// ---- test/test_serial_flash_erase_suspend_power_cmds.sv ----
// Purpose: apb stimulus through the flash host into the flash device
// Assumes: short erase counts; reset gap of 500 covers wake and entry times
// Notes:   expectations from opcodes and id constants only
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_erase_suspend_power_cmds;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        busy, wen, paused, asleep, hs, blank;
  logic [7:0]  paddr;
  logic [5:0]  prot;
  logic [31:0] pwdata, prdata, q;
  int          bad_count, check_count, cyc;
  spi_link_if  link ();
  flash_cmd_host i_flash_cmd_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  // sector count above the suspend latency so a pause can win
  flash_cmd_dev #(.FULL_ERASE_CYC(3000), .SECTOR_ERASE_CYC(4000), .PROGRAM_CYC(100))
    i_flash_cmd_dev (.pclk(pclk), .presetn(presetn), .link(link), .protect_invert(prot[5]),
    .protect_small_unit(prot[4]), .protect_from_bottom(prot[3]), .prot_level_2(prot[2]),
    .prot_level_1(prot[1]), .prot_level_0(prot[0]), .busy(busy), .write_enable_latch(wen),
    .paused_op_flag(paused), .asleep(asleep), .high_speed_standby(hs), .array_blank(blank));
  flash_cmd_link_chk i_flash_cmd_link_chk (.pclk(pclk), .presetn(presetn),
    .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso),
    .miso_oe(link.miso_oe), .miso_line(link.miso_line));
  always #5 pclk = ~pclk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one frame, then poll until frame and gap are both over
  task automatic cmd(input logic [7:0] op, input int tx, input int rx, input logic [23:0] a);
    apb(1'b1, flash_cmd_pkg::REG_ADDR, {8'h00, a});
    apb(1'b1, flash_cmd_pkg::REG_CMD, {1'b1, 15'h0, 4'(rx), 1'b0, 3'(tx), op});
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, flash_cmd_pkg::REG_STAT, 32'h0);
      if (q[1:0] === 2'h0) break;
    end
    chk(8'(q[1:0]), 8'h00);
  endtask
  task automatic t_whole_erase();
    logic [7:0] op;
    cmd(flash_cmd_pkg::OP_CE1, 0, 0, 0);
    chk(8'(busy), 8'h00);
    cmd(flash_cmd_pkg::OP_WREN, 0, 0, 0);
    cmd(flash_cmd_pkg::OP_CE1, 1, 0, 0);
    chk({busy, wen}, 8'h01);
    prot <= 6'h01;
    cmd(flash_cmd_pkg::OP_CE1, 0, 0, 0);
    chk(8'(busy), 8'h00);
    prot <= 6'h00;
    for (int k = 0; k < 2; k++) begin
      op = k ? flash_cmd_pkg::OP_CE2 : flash_cmd_pkg::OP_CE1;
      cmd(flash_cmd_pkg::OP_WREN, 0, 0, 0);
      cmd(flash_cmd_pkg::OP_PP, 4, 0, 0);
      chk(8'(blank), 8'h00);
      cmd(flash_cmd_pkg::OP_WREN, 0, 0, 0);
      cmd(op, 0, 0, 0);
      cmd(flash_cmd_pkg::OP_HALT, 0, 0, 0);
      chk({busy, paused}, 8'h02);
      cmd(flash_cmd_pkg::OP_RDSR, 0, 1, 0);
      chk(8'(q[9:8]), 8'h03);
      for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge pclk);
      chk({busy, wen, blank}, 8'h01);
    end
  endtask
  task automatic pause_sector();
    cmd(flash_cmd_pkg::OP_WREN, 0, 0, 0);
    cmd(flash_cmd_pkg::OP_SE, 3, 0, 0);
    chk(8'(busy), 8'h01);
    cmd(flash_cmd_pkg::OP_HALT, 0, 0, 0);
    for (int i = 0; i < 2000 && paused !== 1'b1; i++) @(posedge pclk);
    chk({busy, paused}, 8'h01);
  endtask
  task automatic t_suspend();
    cmd(flash_cmd_pkg::OP_RES, 0, 0, 0);
    chk(8'(busy), 8'h00);
    pause_sector();
    cmd(flash_cmd_pkg::OP_WREN, 0, 0, 0);
    cmd(flash_cmd_pkg::OP_CE1, 0, 0, 0);
    chk({busy, paused}, 8'h01);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(8'(paused), 8'h00);
    cmd(flash_cmd_pkg::OP_RES, 0, 0, 0);
    chk(8'(busy), 8'h00);
    pause_sector();
    cmd(flash_cmd_pkg::OP_RES, 0, 0, 0);
    chk({busy, paused}, 8'h02);
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge pclk);
    chk(8'(busy), 8'h00);
  endtask
  task automatic t_power_ids();
    cmd(flash_cmd_pkg::OP_FAST, 3, 0, 0);
    chk(8'(hs), 8'h01);
    cmd(flash_cmd_pkg::OP_PD, 0, 0, 0);
    chk({asleep, hs}, 8'h02);
    cmd(flash_cmd_pkg::OP_RDSR, 0, 1, 0);
    chk(q[15:8], 8'hFF);
    // short gap so the next frame lands inside the wake time
    apb(1'b1, flash_cmd_pkg::REG_GAP, 32'h0000000A);
    cmd(flash_cmd_pkg::OP_REL, 0, 0, 0);
    chk(8'(asleep), 8'h00);
    cmd(flash_cmd_pkg::OP_RDSR, 0, 1, 0);
    chk(q[15:8], 8'hFF);
    apb(1'b1, flash_cmd_pkg::REG_GAP, {16'h0000, flash_cmd_pkg::GAP_RESET});
    repeat (400) @(posedge pclk);
    cmd(flash_cmd_pkg::OP_MID, 3, 2, 0);
    chk(q[15:8], flash_cmd_pkg::DEVICE_ID);
    cmd(flash_cmd_pkg::OP_MID, 3, 2, 1);
    chk(q[15:8], flash_cmd_pkg::MANUF_ID);
    cmd(flash_cmd_pkg::OP_FAST, 3, 0, 0);
    cmd(flash_cmd_pkg::OP_WREN, 0, 0, 0);
    chk(8'(hs), 8'h00);
    cmd(flash_cmd_pkg::OP_FAST, 3, 0, 0);
    cmd(flash_cmd_pkg::OP_REL, 3, 1, 0);
    chk(q[15:8], flash_cmd_pkg::DEVICE_ID);
    chk(8'(hs), 8'h00);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    prot = 6'h00;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({busy, paused, asleep}, 8'h00);
    t_whole_erase();
    t_suspend();
    t_power_ids();
    test_done();
  end
endmodule
`default_nettype wire
